//--- rtl/optic_defines.vh
// constants for the option and interrupt control block
`ifndef OPTIC_DEFINES_VH
`define OPTIC_DEFINES_VH

// register byte offsets on the avalon slave
`define OPTIC_ADDR_W 4
`define OPTIC_OFS_CONFIG 4'h0
`define OPTIC_OFS_IRQ 4'h4

// timer_prescale_config fields
`define OPTIC_CFG_PULLUP_DIS 7
`define OPTIC_CFG_EXT_EDGE 6
`define OPTIC_CFG_CLK_SRC 5
`define OPTIC_CFG_PIN_EDGE 4
`define OPTIC_CFG_PRESC_TGT 3
`define OPTIC_CFG_RATE_HI 2
`define OPTIC_CFG_RATE_LO 0
`define OPTIC_CFG_RESET 8'hFF

// irq_control_status fields
`define OPTIC_IRQ_GIE 7
`define OPTIC_IRQ_PERIPHERAL_IRQ_ENABLE 6
`define OPTIC_IRQ_TOIE 5
`define OPTIC_IRQ_EXTIE 4
`define OPTIC_IRQ_PCIE 3
`define OPTIC_IRQ_TOF 2
`define OPTIC_IRQ_EXTF 1
`define OPTIC_IRQ_PCF 0
`define OPTIC_IRQ_RESET 8'h00

// instruction cycle is four oscillator clocks
`define OPTIC_INSTR_DIV_LAST 2'h3
`define OPTIC_NUM_PINS 6

`endif

//--- rtl/optic_ctrl.v
// option/prescaler configuration and core interrupt control with avalon-mm slave
`timescale 1ns/1ps
`include "optic_defines.vh"

module optic_ctrl (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // avalon-mm slave
  input wire [`OPTIC_ADDR_W-1:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  // device pins, asynchronous
  input wire ext_irq_pin_in,
  input wire timer_ext_clock_pin_in,
  input wire [`OPTIC_NUM_PINS-1:0] port_pins_in,
  // same-clock logic around the block
  input wire [`OPTIC_NUM_PINS-1:0] per_pin_change_enable_in,
  input wire [`OPTIC_NUM_PINS-1:0] per_pin_pullup_enable_in,
  input wire timer_overflow_in,
  input wire wdt_base_tick_in,
  input wire wdt_clear_in,
  input wire periph_pending_in,
  // outputs
  output reg [`OPTIC_NUM_PINS-1:0] pullup_enable_out,
  output reg timer_increment_out,
  output reg wdt_timeout_out,
  output reg irq_out
);

  // mask of low prescaler bits that must all be one before the assigned
  // consumer sees a tick; timer gets one extra bit compared to the watchdog
  function [7:0] rate_mask;
    input [2:0] rate;
    input for_timer;
    reg [3:0] bits;
    begin
      bits = {1'b0, rate} + {3'h0, for_timer};
      rate_mask = (8'h01 << bits) - 8'h01;
    end
  endfunction

  // register select, shared by the write enables and the readback mux
  function is_reg;
    input [`OPTIC_ADDR_W-1:0] addr;
    input [`OPTIC_ADDR_W-1:0] ofs;
    begin
      is_reg = (addr == ofs);
    end
  endfunction

  reg [7:0] cfg_q;
  reg [7:0] irq_q;
  reg ack_q;
  reg [1:0] ext_sync_q;
  reg [1:0] tck_sync_q;
  reg [`OPTIC_NUM_PINS-1:0] pin_meta_q;
  reg [`OPTIC_NUM_PINS-1:0] pin_sync_q;
  reg [`OPTIC_NUM_PINS-1:0] pin_prev_q;
  reg ext_prev_q;
  reg tck_prev_q;
  reg [1:0] instr_div_q;
  reg [7:0] presc_q;
  reg [15:0] post_q;

  wire req = avs_read_in | avs_write_in;
  wire accept = req & ack_q;
  wire hit_cfg = is_reg(avs_address_in, `OPTIC_OFS_CONFIG);
  wire hit_irq = is_reg(avs_address_in, `OPTIC_OFS_IRQ);
  // writes land only on the completing edge, never during the wait state
  wire wr_lane0 = accept & avs_write_in & avs_byteenable_in[0];

  wire pullup_dis = cfg_q[`OPTIC_CFG_PULLUP_DIS];
  wire ext_edge = cfg_q[`OPTIC_CFG_EXT_EDGE];
  wire clk_src = cfg_q[`OPTIC_CFG_CLK_SRC];
  wire pin_edge = cfg_q[`OPTIC_CFG_PIN_EDGE];
  wire presc_wdt = cfg_q[`OPTIC_CFG_PRESC_TGT];
  wire [2:0] rate = cfg_q[`OPTIC_CFG_RATE_HI:`OPTIC_CFG_RATE_LO];

  // one wait state: first cycle of a request stalls, the second completes
  assign avs_waitrequest_out = req & ~ack_q;

  always @(posedge clk_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // readback select; unmapped offsets read as zero
  reg [7:0] rd_mux;
  always @* begin
    rd_mux = 8'h00;
    if (hit_cfg) begin
      rd_mux = cfg_q;
    end else if (hit_irq) begin
      rd_mux = irq_q;
    end
  end

  // read data is captured during the wait state so it comes from a flop
  always @(posedge clk_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in & ~ack_q) begin
      avs_readdata_out <= {24'h00_0000, rd_mux};
    end
  end

  // pin synchronisers; the first stage feeds only the second
  always @(posedge clk_in) begin
    if (rst_in) begin
      ext_sync_q <= 2'h0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[0], ext_irq_pin_in};
      ext_prev_q <= ext_sync_q[1];
    end
  end

  // timer clock pin, same two-stage sync plus an edge history flop
  always @(posedge clk_in) begin
    if (rst_in) begin
      tck_sync_q <= 2'h0;
      tck_prev_q <= 1'b0;
    end else begin
      tck_sync_q <= {tck_sync_q[0], timer_ext_clock_pin_in};
      tck_prev_q <= tck_sync_q[1];
    end
  end

  // port pins keep a third stage so a change is seen as sync against prev
  always @(posedge clk_in) begin
    if (rst_in) begin
      pin_meta_q <= {`OPTIC_NUM_PINS{1'b0}};
      pin_sync_q <= {`OPTIC_NUM_PINS{1'b0}};
      pin_prev_q <= {`OPTIC_NUM_PINS{1'b0}};
    end else begin
      pin_meta_q <= port_pins_in;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  wire ext_rise = ext_sync_q[1] & ~ext_prev_q;
  wire ext_fall = ~ext_sync_q[1] & ext_prev_q;
  wire ext_event = ext_edge ? ext_rise : ext_fall;
  wire tck_rise = tck_sync_q[1] & ~tck_prev_q;
  wire tck_fall = ~tck_sync_q[1] & tck_prev_q;
  wire pin_tick = pin_edge ? tck_fall : tck_rise;

  // change is only seen on pins whose individual change enable is set
  wire [`OPTIC_NUM_PINS-1:0] pin_changed;
  genvar gi;
  generate
    for (gi = 0; gi < `OPTIC_NUM_PINS; gi = gi + 1) begin : g_pc
      assign pin_changed[gi] = (pin_sync_q[gi] ^ pin_prev_q[gi]) &
        per_pin_change_enable_in[gi];
    end
  endgenerate
  wire pc_event = |pin_changed;

  // instruction clock tick, oscillator divided by four
  always @(posedge clk_in) begin
    if (rst_in) begin
      instr_div_q <= 2'h0;
    end else begin
      instr_div_q <= instr_div_q + 2'h1;
    end
  end
  wire instr_tick = (instr_div_q == `OPTIC_INSTR_DIV_LAST);
  wire timer_src = clk_src ? pin_tick : instr_tick;

  // single prescaler shared between timer and watchdog
  wire presc_in = presc_wdt ? wdt_base_tick_in : timer_src;
  wire [7:0] mask = rate_mask(rate, ~presc_wdt);
  wire presc_out = presc_in & ((presc_q & mask) == mask);
  wire timer_tick = presc_wdt ? timer_src : presc_out;
  wire wdt_tick = presc_wdt ? presc_out : wdt_base_tick_in;

  // changing the rate mid-count may give one short period; the counter
  // is not cleared on config writes to keep the logic small
  always @(posedge clk_in) begin
    if (rst_in) begin
      presc_q <= 8'h00;
    end else if (presc_in) begin
      presc_q <= presc_q + 8'h01;
    end
  end

  // dedicated watchdog postscaler; timeout pulses on wrap
  always @(posedge clk_in) begin
    if (rst_in) begin
      post_q <= 16'h0000;
      wdt_timeout_out <= 1'b0;
    end else if (wdt_clear_in) begin
      post_q <= 16'h0000;
      wdt_timeout_out <= 1'b0;
    end else begin
      wdt_timeout_out <= wdt_tick & (post_q == 16'hFFFF);
      if (wdt_tick) begin
        post_q <= post_q + 16'h0001;
      end
    end
  end

  // the timer counter lives outside and keeps its value over reset,
  // so only its increment strobe and overflow event pass here
  always @(posedge clk_in) begin
    if (rst_in) begin
      timer_increment_out <= 1'b0;
    end else begin
      timer_increment_out <= timer_tick;
    end
  end

  // configuration register
  always @(posedge clk_in) begin
    if (rst_in) begin
      cfg_q <= `OPTIC_CFG_RESET;
    end else if (wr_lane0 & hit_cfg) begin
      cfg_q <= avs_writedata_in[7:0];
    end
  end

  // control/status: hardware set beats a software clear in the same cycle
  wire [7:0] irq_wr = avs_writedata_in[7:0];
  wire irq_wr_en = wr_lane0 & hit_irq;
  reg [7:0] irq_d;
  always @* begin
    irq_d = irq_q;
    if (irq_wr_en) begin
      irq_d = irq_wr;
    end
    if (timer_overflow_in) begin
      irq_d[`OPTIC_IRQ_TOF] = 1'b1;
    end
    if (ext_event) begin
      irq_d[`OPTIC_IRQ_EXTF] = 1'b1;
    end
    if (pc_event) begin
      irq_d[`OPTIC_IRQ_PCF] = 1'b1;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      irq_q <= `OPTIC_IRQ_RESET;
    end else begin
      irq_q <= irq_d;
    end
  end

  // request to the core
  wire tof_req = irq_q[`OPTIC_IRQ_TOIE] & irq_q[`OPTIC_IRQ_TOF];
  wire ext_req = irq_q[`OPTIC_IRQ_EXTIE] & irq_q[`OPTIC_IRQ_EXTF];
  wire pc_req = irq_q[`OPTIC_IRQ_PCIE] & irq_q[`OPTIC_IRQ_PCF];
  wire per_req = irq_q[`OPTIC_IRQ_PERIPHERAL_IRQ_ENABLE] & periph_pending_in;

  always @(posedge clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_q[`OPTIC_IRQ_GIE] &
        (tof_req | ext_req | pc_req | per_req);
    end
  end

  // pull-ups: the global disable overrides every per-pin enable
  always @(posedge clk_in) begin
    if (rst_in) begin
      pullup_enable_out <= {`OPTIC_NUM_PINS{1'b0}};
    end else begin
      pullup_enable_out <= per_pin_pullup_enable_in &
        {`OPTIC_NUM_PINS{~pullup_dis}};
    end
  end

endmodule // optic_ctrl

//--- dv/optic_ctrl_props.sv
// port assertions for the option and interrupt control block
`timescale 1ns/1ps
module optic_ctrl_props (
  // clock, reset and bus
  input wire clk_in,
  input wire rst_in,
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  // events and outputs
  input wire [5:0] per_pin_pullup_enable_in,
  input wire timer_overflow_in,
  input wire periph_pending_in,
  input wire [5:0] pullup_enable_out,
  input wire timer_increment_out,
  input wire irq_out
);
  reg [7:0] cfg_q;
  reg [7:0] ien_q;
  reg [3:0] age_q;
  wire wr_ok = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];
  wire cfg_wr = wr_ok & (avs_address_in == 4'h0);
  // shadow copies; flag bits are ignored since hardware can set them
  always @(posedge clk_in) begin
    if (rst_in) begin
      cfg_q <= 8'hFF;
      ien_q <= 8'h00;
      age_q <= 4'h0;
    end else begin
      age_q <= cfg_wr ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
      if (cfg_wr)
        cfg_q <= avs_writedata_in[7:0];
      if (wr_ok && avs_address_in == 4'h4)
        ien_q <= avs_writedata_in[7:0];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wait_one_a: assert property ((avs_read_in | avs_write_in) & avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("wait state is not one cycle");
  cfg_read_a: assert property (avs_read_in & !avs_waitrequest_out & avs_address_in == 4'h0
    |-> avs_readdata_out == {24'h0, cfg_q}) else $error("config readback wrong");
  unmapped_read_a: assert property (avs_read_in & !avs_waitrequest_out & avs_address_in != 4'h0
    & avs_address_in != 4'h4
    |-> avs_readdata_out == 0) else $error("unmapped read not zero");
  pullup_gate_a: assert property (1'b1 |=> pullup_enable_out ==
    ($past(per_pin_pullup_enable_in) & {6{~$past(cfg_q[7])}})) else $error("pullup wrong");
  global_block_a: assert property (!ien_q[7] |=> !irq_out) else $error("irq without global");
  periph_irq_a: assert property (periph_pending_in & ien_q[7] & ien_q[6] |=> irq_out)
    else $error("peripheral irq missing");
  overflow_irq_a: assert property (timer_overflow_in & !avs_write_in & ien_q[7] & ien_q[5]
    |-> ##2 irq_out) else $error("overflow irq missing");
  instr_tick_a: assert property (timer_increment_out & age_q == 4'hF & cfg_q[3] & !cfg_q[5]
    |-> $past(timer_increment_out, 4) & !$past(timer_increment_out)) else $error("tick not 1:4");
  cover property (irq_out);
  cover property (timer_increment_out);
  cover property (avs_read_in & !avs_waitrequest_out);
endmodule // optic_ctrl_props
bind optic_ctrl optic_ctrl_props u_props (.clk_in, .rst_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
  .per_pin_pullup_enable_in, .timer_overflow_in, .periph_pending_in, .pullup_enable_out,
  .timer_increment_out, .irq_out);

//--- dv/optic_core_model.sv
// processor core model that takes interrupt requests
`timescale 1ns/1ps
module optic_core_model (
  // clock, reset and request
  input wire clk_in,
  input wire rst_in,
  input wire irq_in,
  // requests taken
  output int taken_out
);
  reg irq_q;
  always @(posedge clk_in) begin
    irq_q <= irq_in & ~rst_in;
    if (irq_in & ~irq_q & ~rst_in)
      taken_out <= taken_out + 1;
  end
endmodule // optic_core_model

//--- dv/tb.sv
// self-checking bench for the option and interrupt control block
`timescale 1ns/1ps
module tb;
  reg clk_in, rst_in, avs_read_in, avs_write_in, ext_irq_pin_in, timer_ext_clock_pin_in;
  reg wdt_base_tick_in, wdt_clear_in, periph_pending_in, timer_overflow_in;
  reg [3:0] avs_address_in, avs_byteenable_in;
  reg [31:0] avs_writedata_in, rd_v;
  reg [5:0] port_pins_in, per_pin_change_enable_in, per_pin_pullup_enable_in;
  wire [31:0] avs_readdata_out;
  wire avs_waitrequest_out, timer_increment_out, wdt_timeout_out, irq_out;
  wire [5:0] pullup_enable_out;
  int miscompares, total_checks, taken, cyc, last, gap, incs, n, i;
  reg [7:0] cfg_m, irq_m;
  optic_ctrl DUT (.clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .ext_irq_pin_in, .timer_ext_clock_pin_in, .port_pins_in, .per_pin_change_enable_in,
    .per_pin_pullup_enable_in, .timer_overflow_in, .wdt_base_tick_in, .wdt_clear_in,
    .periph_pending_in, .pullup_enable_out, .timer_increment_out, .wdt_timeout_out, .irq_out);
  optic_core_model core (.clk_in, .rst_in, .irq_in(irq_out), .taken_out(taken));
  initial begin
    clk_in = 0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (timer_increment_out === 1'b1) begin
      gap <= cyc - last;
      last <= cyc;
      incs <= incs + 1;
    end
  end
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task tally_and_finish;
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // sampling at the falling edge keeps reads clear of the launching edge
  task settle(input int c);
    repeat (c) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task bus(input bit w, input [3:0] a, input [7:0] d);
    int k;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= {24'h0, d};
    avs_write_in <= w;
    avs_read_in <= !w;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (avs_waitrequest_out !== 1'b0 && k < 9);
    if (avs_waitrequest_out !== 1'b0) begin
      miscompares++;
      tally_and_finish;
    end
    rd_v = avs_readdata_out;
    avs_write_in <= 0;
    avs_read_in <= 0;
  endtask
  task wr(input [3:0] a, input [7:0] d);
    bus(1, a, d);
    if (a == 4'h0 && avs_byteenable_in[0])
      cfg_m = d;
    if (a == 4'h4 && avs_byteenable_in[0])
      irq_m = d;
  endtask
  task rd(input [3:0] a);
    bus(0, a, 8'h00);
    chk("readdata", a == 4'h0 ? cfg_m : a == 4'h4 ? irq_m : 8'h00, rd_v);
  endtask
  initial begin
    {avs_read_in, avs_write_in, ext_irq_pin_in, timer_ext_clock_pin_in} = 0;
    {wdt_base_tick_in, wdt_clear_in, periph_pending_in, timer_overflow_in} = 0;
    {avs_address_in, avs_writedata_in} = 0;
    {port_pins_in, per_pin_change_enable_in, per_pin_pullup_enable_in} = 0;
    avs_byteenable_in = 4'hF;
    rst_in = 1;
    cfg_m = 8'hFF;
    irq_m = 8'h00;
    void'($urandom(32'h10C6800A));
    repeat (5) @(posedge clk_in);
    rst_in <= 0;
    rd(4'h0);
    rd(4'h4);
    wr(4'h8, 8'h5A);
    rd(4'h8);
    for (i = 0; i < 4; i++) begin
      avs_byteenable_in <= {3'h0, i != 1};
      wr(4'h0, $urandom);
      rd(4'h0);
      wr(4'h4, $urandom);
      rd(4'h4);
    end
    avs_byteenable_in <= 4'hF;
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h08);
    per_pin_pullup_enable_in <= $urandom;
    settle(40);
    chk("pullup", per_pin_pullup_enable_in, pullup_enable_out);
    chk("gap", 4, gap);
    wr(4'h0, 8'h88);
    settle(2);
    chk("pullup", 0, pullup_enable_out);
    n = taken;
    timer_overflow_in <= 1;
    @(posedge clk_in) timer_overflow_in <= 0;
    irq_m[2] = 1;
    rd(4'h4);
    chk("irq", 0, irq_out);
    wr(4'h4, 8'hA4);
    settle(2);
    chk("irq", 1, irq_out);
    chk("taken", 1, taken - n);
    timer_overflow_in <= 1;
    @(posedge clk_in) timer_overflow_in <= 0;
    rd(4'h4);
    for (i = 0; i < 2; i++) begin
      wr(4'h0, {1'b1, i[0], 6'h08});
      ext_irq_pin_in <= !i[0];
      settle(6);
      wr(4'h4, 8'h00);
      ext_irq_pin_in <= i[0];
      settle(6);
      irq_m[1] = 1;
      rd(4'h4);
      wr(4'h4, 8'h92);
      settle(2);
      chk("irq", 1, irq_out);
      wr(4'h4, 8'h00);
      ext_irq_pin_in <= !i[0];
      settle(6);
      rd(4'h4);
    end
    per_pin_change_enable_in <= 6'h04;
    port_pins_in <= 6'h01;
    settle(6);
    rd(4'h4);
    port_pins_in <= 6'h05;
    settle(6);
    irq_m[0] = 1;
    rd(4'h4);
    wr(4'h4, 8'h89);
    settle(2);
    chk("irq", 1, irq_out);
    periph_pending_in <= 1;
    wr(4'h4, 8'h80);
    settle(2);
    chk("irq", 0, irq_out);
    wr(4'h4, 8'hC0);
    settle(2);
    chk("irq", 1, irq_out);
    periph_pending_in <= 0;
    for (i = 0; i < 8; i++) begin
      wr(4'h0, i[7:0]);
      settle(24 << i);
      chk("gap", 8 << i, gap);
    end
    for (i = 0; i < 2; i++) begin
      wr(4'h0, {3'h1, i[0], 4'h8});
      timer_ext_clock_pin_in <= 0;
      settle(8);
      n = incs;
      timer_ext_clock_pin_in <= 1;
      settle(8);
      chk("rise", !i[0], incs - n);
      n = incs;
      timer_ext_clock_pin_in <= 0;
      settle(8);
      chk("fall", i[0], incs - n);
    end
    wr(4'h0, 8'h08);
    wdt_base_tick_in <= 1;
    wdt_clear_in <= 1;
    @(posedge clk_in) wdt_clear_in <= 0;
    for (i = 0; i < 70000 && wdt_timeout_out !== 1'b1; i++)
      @(negedge clk_in);
    chk("wdt", 1, i > 65530 && i < 65540);
    tally_and_finish;
  end
endmodule // tb
